// [include/sba_defines.vh]
`ifndef SBA_DEFINES_VH
`define SBA_DEFINES_VH
// status codes
`define SBA_ST_INTA 3'h0
`define SBA_ST_IORD 3'h1
`define SBA_ST_IOWR 3'h2
`define SBA_ST_HALT 3'h3
`define SBA_ST_FETCH 3'h4
`define SBA_ST_MRD 3'h5
`define SBA_ST_MWR 3'h6
`define SBA_ST_PASV 3'h7
`define SBA_ST_TOP 2
// modes {io_bus_strap, resident_bus_strap}
`define SBA_MODE_IOONLY 2'h0
`define SBA_MODE_IORES 2'h1
`define SBA_MODE_SINGLE 2'h2
`define SBA_MODE_RESONLY 2'h3
// fsm states
`define SBA_S_IDLE 2'h0
`define SBA_S_REQ 2'h1
`define SBA_S_OWN 2'h2
`endif

// [rtl/sba_arbiter.v]
`timescale 1ns/10ps
`include "sba_defines.vh"
module sba_arbiter (
  input wire clk_sys,
  input wire srst,
  input wire bus_clk,
  input wire cpu_clk,
  input wire [2:0] cpu_cycle_status,
  input wire io_bus_strap,
  input wire resident_bus_strap,
  input wire system_or_resident_select,
  input wire lock_n,
  input wire common_request_hold_n,
  input wire priority_in_n,
  input wire busy_in_n,
  input wire common_bus_request_in_n,
  output reg bus_request_out_n,
  output reg priority_out_n,
  output reg busy_out_n,
  output reg busy_oe,
  output reg common_bus_request_out_n,
  output reg common_bus_request_oe,
  output reg address_enable_handoff_n
);

  // all external inputs except srst pass two flops first; only the second stage is read, plus its delayed copy for the two clocks
  reg [2:0] st_m_r;
  reg [2:0] st_r;
  reg [1:0] bclk_s_r;
  reg [1:0] cclk_s_r;
  reg bclk_d_r;
  reg cclk_d_r;
  reg [1:0] strap_m_r;
  reg [1:0] strap_r;
  reg sel_m_r;
  reg sel_r;
  reg lock_m_r;
  reg lock_r;
  reg hold_m_r;
  reg hold_r;
  reg prio_m_r;
  reg prio_r;
  reg busy_m_r;
  reg busy_r;
  reg common_bus_request_n_m_r;
  reg common_bus_request_n_r;

  // arbitration state, moved only on a sampled bus clock fall
  reg [1:0] state_r;
  reg [1:0] state_nxt;

  // slow status and straps still cross domains, so they are synchronised too
  always @(posedge clk_sys) begin
    st_m_r <= cpu_cycle_status;
    st_r <= st_m_r;
  end

  // edge finders compare the second stage with its own delayed copy
  always @(posedge clk_sys) begin
    bclk_s_r <= {bclk_s_r[0], bus_clk};
    bclk_d_r <= bclk_s_r[1];
  end

  always @(posedge clk_sys) begin
    cclk_s_r <= {cclk_s_r[0], cpu_clk};
    cclk_d_r <= cclk_s_r[1];
  end

  always @(posedge clk_sys) begin
    strap_m_r <= {io_bus_strap, resident_bus_strap};
    strap_r <= strap_m_r;
  end

  // select may change per cycle, so it is never read unsynchronised
  always @(posedge clk_sys) begin
    sel_m_r <= system_or_resident_select;
    sel_r <= sel_m_r;
  end

  // lock inputs are levels held across many cycles
  always @(posedge clk_sys) begin
    lock_m_r <= lock_n;
    lock_r <= lock_m_r;
  end

  always @(posedge clk_sys) begin
    hold_m_r <= common_request_hold_n;
    hold_r <= hold_m_r;
  end

  // priority-in high means a higher arbiter wants the bus
  always @(posedge clk_sys) begin
    prio_m_r <= priority_in_n;
    prio_r <= prio_m_r;
  end

  // wired busy and common request lines, shared with every peer
  always @(posedge clk_sys) begin
    busy_m_r <= busy_in_n;
    busy_r <= busy_m_r;
  end

  always @(posedge clk_sys) begin
    common_bus_request_n_m_r <= common_bus_request_in_n;
    common_bus_request_n_r <= common_bus_request_n_m_r;
  end

  // bus-side changes on the falling edge of the bus clock
  wire bclk_fall = bclk_d_r & ~bclk_s_r[1];
  wire cclk_rise = ~cclk_d_r & cclk_s_r[1];

  function is_mem;
    input [2:0] s;
    begin
      is_mem = s[`SBA_ST_TOP] & (s != `SBA_ST_PASV);
    end
  endfunction

  function is_io;
    input [2:0] s;
    begin
      is_io = ~s[`SBA_ST_TOP] & (s != `SBA_ST_HALT);
    end
  endfunction

  // any cycle that drives the shared bus; halt and passive excluded
  function is_access;
    input [2:0] s;
    begin
      is_access = is_mem(s) | is_io(s);
    end
  endfunction

  // decoded cycle types and qualified wired-line conditions
  wire halt_state = (st_r == `SBA_ST_HALT);
  wire idle_state = (st_r == `SBA_ST_PASV);
  wire higher_priority_request = prio_r;
  // common request from any peer, unless the hold input masks it
  wire common_bus_request_n_seen = ~common_bus_request_n_r;
  wire common_bus_request_n_true = common_bus_request_n_seen & hold_r;

  reg want;
  reg give_up;

  // request side: which decoded cycles need the shared bus in each mode
  always @* begin
    want = 1'b0;
    case (strap_r)
      `SBA_MODE_SINGLE: begin
        want = is_access(st_r);
      end
      `SBA_MODE_RESONLY: begin
        want = sel_r & is_access(st_r);
      end
      `SBA_MODE_IOONLY: begin
        want = is_mem(st_r);
      end
      default: begin
        want = sel_r & is_mem(st_r);
      end
    endcase
    // halt and passive never request
    if (halt_state | idle_state) begin
      want = 1'b0;
    end
  end

  // surrender side; the processor lock overrides every release path
  always @* begin
    give_up = 1'b0;
    case (strap_r)
      `SBA_MODE_SINGLE: begin
        give_up = idle_state & common_bus_request_n_true;
      end
      `SBA_MODE_RESONLY: begin
        give_up = (~sel_r | idle_state) & common_bus_request_n_true;
      end
      `SBA_MODE_IOONLY: begin
        give_up = (is_io(st_r) | idle_state) & common_bus_request_n_true;
      end
      default: begin
        give_up = (is_io(st_r) | ~sel_r) & common_bus_request_n_true;
      end
    endcase
    give_up = give_up | halt_state | higher_priority_request;
    if (~lock_r) begin
      give_up = 1'b0;
    end
  end

  // a request dropped while waiting returns to idle unless the lock holds it
  always @* begin
    state_nxt = state_r;
    case (state_r)
      `SBA_S_IDLE: begin
        if (want) begin
          state_nxt = `SBA_S_REQ;
        end
      end
      `SBA_S_REQ: begin
        if (~want & lock_r) begin
          state_nxt = `SBA_S_IDLE;
        end else if (~prio_r & busy_r) begin
          state_nxt = `SBA_S_OWN;
        end
      end
      `SBA_S_OWN: begin
        if (give_up & ~want) begin
          state_nxt = `SBA_S_IDLE;
        end
      end
      default: begin
        state_nxt = `SBA_S_IDLE;
      end
    endcase
  end

  // decoded next state, shared by every bus-side output
  wire nxt_active = (state_nxt != `SBA_S_IDLE);
  wire nxt_wait = (state_nxt == `SBA_S_REQ);
  wire nxt_own = (state_nxt == `SBA_S_OWN);

  // state moves only on a sampled bus clock fall; priority_out_n and address_enable_handoff_n can also change between falls
  always @(posedge clk_sys) begin
    if (srst) begin
      state_r <= `SBA_S_IDLE;
    end else if (bclk_fall) begin
      state_r <= state_nxt;
    end
  end

  // request stays low from the first fall of a wanted cycle until release
  always @(posedge clk_sys) begin
    if (srst) begin
      bus_request_out_n <= 1'b1;
    end else if (bclk_fall) begin
      bus_request_out_n <= ~nxt_active;
    end
  end

  // pass lower priority on only when we do not want the bus
  always @(posedge clk_sys) begin
    if (srst) begin
      priority_out_n <= 1'b1;
    end else if (bclk_fall) begin
      priority_out_n <= prio_r | nxt_active;
    end else if (prio_r & ~priority_out_n) begin
      // a rise of priority-in ripples through without waiting for a bus edge; a fall waits for the next bus clock fall
      priority_out_n <= 1'b1;
    end
  end

  // wired lines are only ever pulled low, never driven high
  always @(posedge clk_sys) begin
    if (srst) begin
      busy_out_n <= 1'b1;
      busy_oe <= 1'b0;
    end else if (bclk_fall) begin
      busy_oe <= nxt_own;
      busy_out_n <= ~nxt_own;
    end
  end

  // common request is pulled only while waiting for a grant
  always @(posedge clk_sys) begin
    if (srst) begin
      common_bus_request_out_n <= 1'b1;
      common_bus_request_oe <= 1'b0;
    end else if (bclk_fall) begin
      common_bus_request_oe <= nxt_wait;
      common_bus_request_out_n <= ~nxt_wait;
    end
  end

  // a grant on the same edge as a processor clock rise must not be lost
  always @(posedge clk_sys) begin
    if (srst) begin
      address_enable_handoff_n <= 1'b1;
    end else if (bclk_fall & nxt_own) begin
      address_enable_handoff_n <= 1'b0;
    end else if (cclk_rise & (state_r != `SBA_S_OWN)) begin
      address_enable_handoff_n <= 1'b1;
    end
  end

endmodule // sba_arbiter

// [dv/sba_peer_model.sv]
`timescale 1ns/10ps
module sba_peer_model (
  input wire bus_clk,
  input wire want,
  input wire cb,
  output reg priority_in_n,
  output reg peer_busy_n,
  output reg peer_common_bus_request_n_n
);
  always @(negedge bus_clk) begin
    priority_in_n <= want;
    peer_busy_n <= !want;
    peer_common_bus_request_n_n <= !cb;
  end
endmodule // sba_peer_model

// [dv/sba_arbiter_assertions.sv]
`timescale 1ns/10ps
module sba_arbiter_assertions (
  input wire clk_sys,
  input wire srst,
  input wire lock_n,
  input wire priority_in_n,
  input wire bus_request_out_n,
  input wire priority_out_n,
  input wire busy_out_n,
  input wire busy_oe,
  input wire common_bus_request_out_n,
  input wire common_bus_request_oe,
  input wire address_enable_handoff_n
);
  default clocking @(posedge clk_sys); endclocking
  default disable iff (srst);
  property p_busy; busy_oe |-> !busy_out_n; endproperty
  a_busy: assert property (p_busy) else $error("busy");
  property p_wait; common_bus_request_oe |-> !common_bus_request_out_n && !bus_request_out_n; endproperty
  a_wait: assert property (p_wait) else $error("wait");
  property p_pri; $rose(priority_in_n) |-> ##[1:4] priority_out_n; endproperty
  a_pri: assert property (p_pri) else $error("pri");
  property p_lock; !lock_n && !$past(lock_n, 3) && $past(busy_oe) |-> busy_oe; endproperty
  a_lock: assert property (p_lock) else $error("lock");
  property p_grant; $rose(busy_oe) |-> !address_enable_handoff_n && !bus_request_out_n; endproperty
  a_grant: assert property (p_grant) else $error("grant");
  property p_take; $rose(busy_oe) |-> !common_bus_request_oe; endproperty
  a_take: assert property (p_take) else $error("take");
  property p_aen; $rose(address_enable_handoff_n) |-> !busy_oe; endproperty
  a_aen: assert property (p_aen) else $error("aen");
  property p_rst; $fell(srst) |-> bus_request_out_n && !busy_oe && !common_bus_request_oe; endproperty
  a_rst: assert property (p_rst) else $error("rst");
endmodule // sba_arbiter_assertions
bind sba_arbiter sba_arbiter_assertions chk_u (.*);

// [dv/sba_arbiter_tb.sv]
`timescale 1ns/10ps
module sba_arbiter_tb;
  logic clk_sys = 1'h0, srst = 1'h1, bus_clk = 1'h0, cpu_clk = 1'h0, want = 1'h0, cb = 1'h0;
  logic io_bus_strap = 1'h0, resident_bus_strap = 1'h0, system_or_resident_select = 1'h0;
  logic lock_n = 1'h1, common_request_hold_n = 1'h1;
  logic [2:0] cpu_cycle_status = 3'h7;
  logic [17:0] rows [4] = '{18'h2_7777, 18'h3_7700, 18'h0_7070, 18'h1_7000};
  logic [4:0] surr [5] = '{5'h0d, 5'h13, 5'h1c, 5'h1a, 5'h14};
  integer n_mismatch = 0, checks_done = 0, i, j;
  wire priority_in_n, peer_busy_n, peer_common_bus_request_n_n, bus_request_out_n, priority_out_n, busy_out_n, busy_oe;
  wire common_bus_request_out_n, common_bus_request_oe, address_enable_handoff_n;
  wire busy_in_n = (busy_oe ? busy_out_n : 1'h1) & peer_busy_n;
  wire common_bus_request_in_n = (common_bus_request_oe ? common_bus_request_out_n : 1'h1) & peer_common_bus_request_n_n;
  always #2 clk_sys = ~clk_sys;
  // offset keeps the slow clocks off the sampling edge
  initial begin #1; forever #32 bus_clk = ~bus_clk; end
  initial begin #1; forever #10 cpu_clk = ~cpu_clk; end
  sba_arbiter dut_u (.*);
  sba_peer_model peer_u (.*);
  task chk(input [1:0] got, input [1:0] exp);
    checks_done = checks_done + 1;
    if (got !== exp) begin
      n_mismatch = n_mismatch + 1;
      $display("MISMATCH %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task wt(input integer n); repeat (n) @(posedge clk_sys); endtask
  task rst; srst <= 1'h1; wt(5); srst <= 1'h0; wt(3); endtask
  task tally_and_finish;
    $display("checks %0d mismatches %0d", checks_done, n_mismatch);
    if (n_mismatch == 0 && checks_done > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  initial begin
    for (i = 0; i < 4; i = i + 1) begin
      for (j = 0; j < 16; j = j + 1) begin
        rst;
        {io_bus_strap, resident_bus_strap, system_or_resident_select, cpu_cycle_status} <= {rows[i][17:16], j[3:0]};
        wt(64);
        chk({bus_request_out_n, address_enable_handoff_n}, {2{~rows[i][j]}});
        chk({priority_out_n, busy_oe}, {2{rows[i][j]}});
      end
    end
    $display("mode table done");
    for (i = 0; i < 5; i = i + 1) begin
      rst;
      {io_bus_strap, resident_bus_strap, cpu_cycle_status} <= 5'h15;
      wt(64);
      chk({1'h0, busy_oe}, 2'h1);
      {lock_n, common_request_hold_n, want, cb, cpu_cycle_status} <= {surr[i][4:1], 3'h7};
      wt(64);
      chk({1'h0, busy_oe}, {1'h0, surr[i][0]});
      {lock_n, common_request_hold_n, want, cb} <= 4'hc;
    end
    $display("surrender done");
    rst;
    {want, cpu_cycle_status} <= 4'hd;
    wt(64);
    chk({address_enable_handoff_n, common_bus_request_oe}, 2'h3);
    chk({priority_out_n, common_bus_request_out_n}, 2'h2);
    want <= 1'h0;
    wt(64);
    chk({address_enable_handoff_n, busy_oe}, 2'h1);
    chk({priority_out_n, busy_out_n}, 2'h2);
    $display("priority done");
    srst <= 1'h1;
    wt(2);
    chk({bus_request_out_n, busy_oe}, 2'h2);
    chk({address_enable_handoff_n, common_bus_request_oe}, 2'h2);
    srst <= 1'h0;
    $display("reset done");
    tally_and_finish;
  end
  initial begin
    #100000;
    n_mismatch = n_mismatch + 1;
    tally_and_finish;
  end
endmodule // sba_arbiter_tb
